// *** common/asws_pkg.sv ***
`default_nettype none
package asws_pkg;

   localparam int NUM_CS    = 4;
   localparam int CS_W      = 2;
   localparam int ADDR_W    = 20;
   localparam int WADDR_W   = 18;
   localparam int BA_W      = 2;
   localparam int DATA_W    = 16;
   localparam int WORD_W    = 32;
   localparam int CNT_W     = 6;
   localparam int BEAT_W    = 3;

   // beats per 32-bit word on a 16-bit or an 8-bit memory
   localparam logic [BEAT_W-1:0] BEATS_WIDE   = 3'h2;
   localparam logic [BEAT_W-1:0] BEATS_NARROW = 3'h4;
   localparam logic [CNT_W-1:0]  CNT_ONE      = 6'h01;
   localparam logic [CNT_W-1:0]  CNT_ZERO     = 6'h00;
   localparam logic [CS_W-1:0]   CS_RESET     = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RESET   = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_RESET   = 32'h00000000;

   // per chip-select timing, counts in interface clock cycles
   typedef struct packed {
      logic [3:0] w_setup;
      logic [5:0] w_strobe;
      logic [2:0] w_hold;
      logic [3:0] r_setup;
      logic [5:0] r_strobe;
      logic [2:0] r_hold;
      logic [1:0] turnaround_count;
      logic       narrow8;
   } asws_cfg_s;

   typedef struct packed {
      logic               write;
      logic [CS_W-1:0]    cs;
      logic [BA_W-1:0]    bank;
      logic [WADDR_W-1:0] waddr;
      logic [WORD_W-1:0]  wdata;
   } asws_req_s;

   localparam asws_req_s REQ_RESET = '0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_TURN   = 3'h1,
      ST_SETUP  = 3'h3,
      ST_STROBE = 3'h2,
      ST_HOLD   = 3'h6
   } asws_state_e;

endpackage : asws_pkg
`default_nettype wire

// *** design/asws_sequencer.sv ***
`default_nettype none
module asws_sequencer
   import asws_pkg::*;
(
   // clock and reset
   input  wire  logic                  sys_clk,
   input  wire  logic                  nrst,
   // chip-select configuration
   input  wire  asws_cfg_s             cs_cfg [NUM_CS],
   // requests from the on-chip bus
   input  wire  logic                  req_valid,
   input  wire  asws_req_s             req,
   output logic                        req_ready,
   output logic                        rd_valid,
   output logic [WORD_W-1:0]           rd_data,
   output logic                        busy,
   // external memory pins
   output logic [NUM_CS-1:0]           chip_select_n,
   output logic                        write_strobe_n,
   output logic                        output_enable_n,
   output logic                        rw_direction,
   output logic [ADDR_W-1:0]           mem_addr_bus,
   output logic [BA_W-1:0]             bank_addr_pins,
   input  wire  logic [DATA_W-1:0]     mem_data_bus_in,
   output logic [DATA_W-1:0]           mem_data_bus_out,
   output logic                        mem_data_bus_oe
);

   function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] v);
      at_least_one = (v == CNT_ZERO) ? CNT_ONE : v;
   endfunction

   function automatic logic [DATA_W-1:0] beat_slice(input logic [WORD_W-1:0] w,
                                                    input logic [BEAT_W-1:0] b,
                                                    input logic              n8);
      logic [WORD_W-1:0] s;
      s = n8 ? (w >> {b, 3'h0}) : (w >> {b, 4'h0});
      beat_slice = n8 ? {8'h00, s[7:0]} : s[DATA_W-1:0];
   endfunction

   asws_state_e             state;
   asws_state_e             next_state;
   asws_req_s               op;
   logic                    op_narrow;
   logic [CNT_W-1:0]        cnt;
   logic [CNT_W-1:0]        next_cnt;
   logic [CNT_W-1:0]        setup_len;
   logic [CNT_W-1:0]        strobe_len;
   logic [CNT_W-1:0]        hold_len;
   logic [BEAT_W-1:0]       beat_left;
   logic [BEAT_W-1:0]       beat_idx;
   logic [DATA_W-1:0]       din_s1;
   logic [DATA_W-1:0]       din_s2;

   // decode of the current phase
   wire                     phase_end   = (cnt == CNT_ONE);
   wire                     last_beat   = (beat_left == 3'h1);
   wire                     hold_end    = (state == ST_HOLD) && phase_end;
   wire                     hold_last   = hold_end && last_beat;
   wire                     accept      = req_valid && req_ready;

   // a new request may enter in idle or as the last beat finishes
   assign req_ready = (state == ST_IDLE) || hold_last;
   assign busy      = (state != ST_IDLE);

   wire asws_cfg_s          req_cfg     = cs_cfg[req.cs];
   wire asws_cfg_s          op_cfg      = cs_cfg[op.cs];
   wire                     b2b_write   = hold_last && op.write && req.write && (req.cs == op.cs);
   wire                     ta_zero     = (req_cfg.turnaround_count == 2'h0);
   wire [CNT_W-1:0]         ta_full     = {4'h0, req_cfg.turnaround_count};
   wire [CNT_W-1:0]         ta_b2b      = ta_zero ? CNT_ONE : CNT_ZERO;
   wire [CNT_W-1:0]         ta_len      = b2b_write ? ta_b2b : ta_full;
   wire asws_state_e        start_state = (ta_len == CNT_ZERO) ? ST_SETUP : ST_TURN;

   // counts loaded only on a fresh entry into setup
   wire asws_cfg_s          ld_cfg      = accept ? req_cfg : op_cfg;
   wire                     ld_write    = accept ? req.write : op.write;
   wire [CNT_W-1:0]         ld_setup    = ld_write ? {2'h0, ld_cfg.w_setup} : {2'h0, ld_cfg.r_setup};
   wire [CNT_W-1:0]         ld_strobe   = ld_write ? ld_cfg.w_strobe : ld_cfg.r_strobe;
   wire [CNT_W-1:0]         ld_hold     = ld_write ? {3'h0, ld_cfg.w_hold} : {3'h0, ld_cfg.r_hold};
   wire                     fresh_setup = (next_state == ST_SETUP) && (accept || state == ST_TURN);

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (accept)
               next_state = start_state;
         end
         ST_TURN:
         begin
            if (phase_end)
               next_state = ST_SETUP;
         end
         ST_SETUP:
         begin
            if (phase_end)
               next_state = ST_STROBE;
         end
         ST_STROBE:
         begin
            if (phase_end)
               next_state = ST_HOLD;
         end
         ST_HOLD:
         begin
            if (hold_end && !last_beat)
               next_state = ST_SETUP;
            else if (hold_last)
               next_state = accept ? start_state : ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // phase length on entry, countdown while staying
   wire                     phase_change = (next_state != state) || (hold_end && !last_beat);
   logic [CNT_W-1:0]        enter_len;

   always_comb
   begin
      case (next_state)
         ST_TURN:   enter_len = ta_len;
         ST_SETUP:  enter_len = fresh_setup ? at_least_one(ld_setup) : setup_len;
         ST_STROBE: enter_len = strobe_len;
         ST_HOLD:   enter_len = hold_len;
         default:   enter_len = CNT_ONE;
      endcase
   end

   assign next_cnt = phase_change ? enter_len : cnt - CNT_ONE;

   // values the pins take in the next phase
   wire asws_req_s          next_op     = accept ? req : op;
   wire                     next_narrow = accept ? req_cfg.narrow8 : op_narrow;
   wire [BEAT_W-1:0]        next_beat   = accept ? 3'h0 : (hold_end ? beat_idx + 3'h1 : beat_idx);
   wire                     nxt_active  = (next_state == ST_SETUP) || (next_state == ST_STROBE)
                                          || (next_state == ST_HOLD);
   wire                     nxt_strobe  = (next_state == ST_STROBE);
   wire                     nxt_write   = nxt_active && next_op.write;
   wire [ADDR_W-1:0]        nxt_addr    = next_narrow ? {next_op.waddr, next_beat[1:0]}
                                                      : {1'b0, next_op.waddr, next_beat[0]};
   wire [NUM_CS-1:0]        nxt_cs_n    = ~({{(NUM_CS-1){1'b0}}, nxt_strobe} << next_op.cs);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state      <= ST_IDLE;
         cnt        <= CNT_ONE;
         op         <= REQ_RESET;
         op_narrow  <= 1'b0;
         setup_len  <= CNT_ONE;
         strobe_len <= CNT_ONE;
         hold_len   <= CNT_ONE;
         beat_left  <= BEATS_WIDE;
         beat_idx   <= 3'h0;
      end
      else
      begin
         state    <= next_state;
         cnt      <= next_cnt;
         beat_idx <= next_beat;
         if (accept)
         begin
            op        <= req;
            op_narrow <= req_cfg.narrow8;
            beat_left <= req_cfg.narrow8 ? BEATS_NARROW : BEATS_WIDE;
         end
         else if (hold_end)
            beat_left <= beat_left - 3'h1;
         if (fresh_setup)
         begin
            setup_len  <= at_least_one(ld_setup);
            strobe_len <= at_least_one(ld_strobe);
            hold_len   <= at_least_one(ld_hold);
         end
      end
   end

   // pins are registered from the next phase so they switch on phase entry
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         chip_select_n    <= {NUM_CS{1'b1}};
         write_strobe_n   <= 1'b1;
         output_enable_n  <= 1'b1;
         rw_direction     <= 1'b1;
         mem_addr_bus     <= ADDR_RESET;
         bank_addr_pins   <= CS_RESET;
         mem_data_bus_out <= DATA_RESET;
         mem_data_bus_oe  <= 1'b0;
      end
      else
      begin
         chip_select_n    <= nxt_cs_n;
         write_strobe_n   <= !(nxt_strobe && next_op.write);
         output_enable_n  <= !(nxt_strobe && !next_op.write);
         rw_direction     <= !nxt_write;
         mem_addr_bus     <= nxt_active ? nxt_addr : ADDR_RESET;
         bank_addr_pins   <= nxt_active ? next_op.bank : CS_RESET;
         mem_data_bus_out <= nxt_write ? beat_slice(next_op.wdata, next_beat, next_narrow)
                                       : DATA_RESET;
         mem_data_bus_oe  <= nxt_write;
      end
   end

   // read data: pin synchronised, so the bus must be stable two cycles before hold
   wire                     rd_sample  = (state == ST_STROBE) && phase_end && !op.write;
   wire [WORD_W-1:0]        rd_lane8   = {24'h000000, din_s2[7:0]} << {beat_idx, 3'h0};
   wire [WORD_W-1:0]        rd_lane16  = {16'h0000, din_s2} << {beat_idx, 4'h0};
   wire [WORD_W-1:0]        rd_lane    = op_narrow ? rd_lane8 : rd_lane16;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         din_s1   <= DATA_RESET;
         din_s2   <= DATA_RESET;
         rd_data  <= WORD_RESET;
         rd_valid <= 1'b0;
      end
      else
      begin
         din_s1   <= mem_data_bus_in;
         din_s2   <= din_s1;
         rd_valid <= hold_last && !op.write;
         if (rd_sample)
            rd_data <= (beat_idx == 3'h0) ? rd_lane : (rd_data | rd_lane);
      end
   end

endmodule // asws_sequencer
`default_nettype wire

// *** testbench/asws_props.sv ***
`default_nettype none
module asws_props
   import asws_pkg::*;
(
   // clock, reset, requests
   input wire logic              sys_clk,
   input wire logic              nrst,
   input wire logic              req_valid,
   input wire asws_req_s         req,
   input wire logic              req_ready,
   input wire logic              busy,
   // memory pins
   input wire logic [NUM_CS-1:0] chip_select_n,
   input wire logic              write_strobe_n,
   input wire logic              output_enable_n,
   input wire logic              rw_direction,
   input wire logic              mem_data_bus_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_wtake; req_valid && req_ready && req.write; endsequence
   sequence s_strobe_on; $fell(write_strobe_n); endsequence
   a_read_we_high: assert property (!output_enable_n |-> write_strobe_n && rw_direction)
      else $error("write pins active in a read");
   a_write_oe_high: assert property (!rw_direction |-> output_enable_n)
      else $error("output enable active in a write");
   a_turn_bound: assert property (s_wtake |-> ##[1:4] !rw_direction)
      else $error("write setup late");
   a_write_drive: assert property (!write_strobe_n |-> mem_data_bus_oe && !rw_direction)
      else $error("bus not driven in strobe");
   a_strobe_cs: assert property (s_strobe_on |-> $countones(~chip_select_n) == 1)
      else $error("no single chip select in strobe");
   a_hold_cs: assert property ($rose(write_strobe_n) |-> &chip_select_n && !rw_direction)
      else $error("chip select low in hold");
   a_rw_release: assert property ($rose(rw_direction) |-> !mem_data_bus_oe)
      else $error("data driven after direction rise");
   a_strobe_len: assert property (s_strobe_on |-> ##[1:64] $rose(write_strobe_n))
      else $error("strobe too long");
   a_idle_ready: assert property (!busy |-> req_ready && (&chip_select_n) && write_strobe_n
                                  && output_enable_n && rw_direction && !mem_data_bus_oe)
      else $error("idle but not ready");
endmodule // asws_props
bind asws_sequencer asws_props u_props (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .busy(busy), .chip_select_n(chip_select_n),
   .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
   .rw_direction(rw_direction), .mem_data_bus_oe(mem_data_bus_oe));
`default_nettype wire

// *** testbench/asws_sram_model.sv ***
`default_nettype none
module asws_sram_model
   import asws_pkg::*;
(
   // memory pins
   input  wire logic [ADDR_W-1:0] mem_addr_bus,
   input  wire logic              write_strobe_n,
   input  wire logic              output_enable_n,
   input  wire logic [DATA_W-1:0] mem_data_bus_out,
   output logic      [DATA_W-1:0] mem_data_bus_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] last = DATA_RESET;
   always @*
      if (!write_strobe_n)
         mem[mem_addr_bus] = mem_data_bus_out;
   // released bus shows the inverse of the last word, so stale data never passes
   always @(posedge output_enable_n)
      last = mem[mem_addr_bus];
   assign mem_data_bus_in = output_enable_n ? ~last : mem[mem_addr_bus];
endmodule // asws_sram_model
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench
   import asws_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [NUM_CS-1:0] cs_n;
      logic [BA_W-1:0]   bank;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [CNT_W-1:0]  slen;
      logic [CNT_W-1:0]  lead;
   } asws_beat_s;
   logic               sys_clk = 1'b0;
   logic               nrst = 1'b0;
   logic               req_valid = 1'b0;
   asws_req_s          req = REQ_RESET;
   asws_cfg_s          cfg [NUM_CS];
   logic               req_ready, rd_valid, busy, write_strobe_n, output_enable_n;
   logic               rw_direction, mem_data_bus_oe, pw, wprev = 1'b1;
   logic [NUM_CS-1:0]  chip_select_n;
   logic [ADDR_W-1:0]  mem_addr_bus;
   logic [BA_W-1:0]    bank_addr_pins;
   logic [CS_W-1:0]    c, pc, lw_c;
   logic [DATA_W-1:0]  mem_data_bus_in, mem_data_bus_out;
   logic [WADDR_W-1:0] a, lw_a;
   logic [WORD_W-1:0]  rd_data, op, d, lw_d;
   int                 failures = 0, n_checks = 0, cnt = 0, seed = 32'hae81372e;
   asws_beat_s         wq [$];
   asws_beat_s         got;
   logic [WORD_W-1:0]  rq [$];
   asws_sequencer dut (.sys_clk(sys_clk), .nrst(nrst), .cs_cfg(cfg), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
      .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .output_enable_n(output_enable_n), .rw_direction(rw_direction),
      .mem_addr_bus(mem_addr_bus), .bank_addr_pins(bank_addr_pins),
      .mem_data_bus_in(mem_data_bus_in), .mem_data_bus_out(mem_data_bus_out),
      .mem_data_bus_oe(mem_data_bus_oe));
   asws_sram_model u_mem (.mem_addr_bus(mem_addr_bus), .write_strobe_n(write_strobe_n),
      .output_enable_n(output_enable_n), .mem_data_bus_out(mem_data_bus_out),
      .mem_data_bus_in(mem_data_bus_in));
   always #25 sys_clk = ~sys_clk;
   function automatic logic [CNT_W-1:0] cl(input logic [CNT_W-1:0] v);
      return (v == CNT_ZERO) ? CNT_ONE : v;
   endfunction
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_beat(input asws_beat_s e, input asws_beat_s g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("BAD beat expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_word(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("BAD rd_data expected %h seen %h", e, g);
      end
   endtask
   // waits are bounded: a stuck handshake ends the run as a failure
   task automatic wait_low(input logic busy_wait);
      int k;
      k = 0;
      // a request left standing after it was taken would be taken again at the next ready
      if (busy_wait)
         req_valid = 1'b0;
      @(negedge sys_clk);
      while ((busy_wait ? busy : !req_ready) && k < 600)
      begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 600)
      begin
         failures++;
         results();
      end
      @(posedge sys_clk);
      #2;
   endtask
   task automatic send(input asws_req_s r);
      req = r;
      req_valid = 1'b1;
      wait_low(1'b0);
   endtask
   task automatic wr(input logic b2b);
      asws_beat_s       e;
      logic [CNT_W-1:0] su, tn;
      su = cl(CNT_W'(cfg[c].w_setup));
      tn = b2b ? CNT_W'(cfg[c].turnaround_count == 2'h0) : CNT_W'(cfg[c].turnaround_count);
      for (int b = 0; b < (cfg[c].narrow8 ? 4 : 2); b++)
      begin
         e.cs_n = ~(4'h1 << c);
         e.bank = d[31:30];
         e.addr = cfg[c].narrow8 ? {a, 2'(b)} : {1'b0, a, 1'(b)};
         e.data = cfg[c].narrow8 ? {8'h00, d[8*b +: 8]} : d[16*b +: 16];
         e.slen = cl(cfg[c].w_strobe);
         e.lead = (b == 0) ? tn + su + CNT_ONE : cl(CNT_W'(cfg[c].w_hold)) + su;
         wq.push_back(e);
      end
      send('{1'b1, c, d[31:30], a, d});
   endtask
   always @(negedge sys_clk)
   begin
      cnt++;
      if (!write_strobe_n && wprev)
      begin
         got = '{chip_select_n, bank_addr_pins, mem_addr_bus, mem_data_bus_out, CNT_ZERO, 6'(cnt)};
         cnt = 0;
      end
      if (write_strobe_n && !wprev)
      begin
         got.slen = 6'(cnt);
         cnt = 0;
         chk_beat(wq.size() > 0 ? wq.pop_front() : '0, got);
      end
      if (req_valid && req_ready)
         cnt = 0;
      if (rd_valid)
         chk_word(rq.size() > 0 ? rq.pop_front() : '0, rd_data);
      wprev = write_strobe_n;
   end
   initial
   begin
      for (int i = 0; i < NUM_CS; i++)
         cfg[i] = '0;
      repeat (20) @(posedge sys_clk);
      #2;
      nrst = 1'b1;
      for (int r = 0; r < 2; r++)
      begin
         // reads need a strobe of at least 3 cycles for the input synchroniser
         for (int i = 0; i < NUM_CS; i++)
            cfg[i] = asws_cfg_s'(29'($random(seed)) | 29'h00000800);
         cfg[r].turnaround_count = 2'h0;
         pw = 1'b0;
         for (int i = 0; i < 12; i++)
         begin
            op = $random(seed);
            if (op[0])
               wait_low(1'b1);
            if (i > 0 && op[2:1] == 2'h0)
            begin
               rq.push_back(lw_d);
               send('{1'b0, lw_c, op[6:5], lw_a, WORD_RESET});
               pw = 1'b0;
            end
            else
            begin
               c = op[4:3];
               a = op[25:8];
               d = $random(seed);
               wr(!op[0] && pw && pc == c);
               pw = 1'b1;
               pc = c;
               lw_c = c;
               lw_a = a;
               lw_d = d;
            end
         end
         wait_low(1'b1);
      end
      chk_word(WORD_RESET, WORD_W'(wq.size() + rq.size()));
      results();
   end
endmodule // testbench
`default_nettype wire
